// ===== design/cal_link_pkg.sv
// Constants, register map and carrier types for the calibration and link configuration block.
// Assumes an APB slave with 32-bit data and a 250 MHz pclk.
package cal_link_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] LINK_CFG_OFFSET = 12'h004;
  localparam logic [11:0] DRIVER_OFFSET = 12'h008;
  localparam logic [11:0] LINK_STATUS_OFFSET = 12'h00c;
  localparam logic [11:0] PARAMS_OFFSET = 12'h010;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int PWRDN_BIT = 0;
  localparam int OFFSET_BIN_BIT = 1;
  localparam int SCRAMBLE_BIT = 2;
  localparam int SUBCLASS_BIT = 3;
  localparam int DIV_LSB = 4;
  localparam int TEST_LSB = 8;
  localparam int SYSREF_MODE_LSB = 12;

  // ----------------------------------------------------------------
  // Link configuration and driver fields
  // ----------------------------------------------------------------
  localparam int LANES_A_BIT = 0;
  localparam int LANES_B_BIT = 1;
  localparam int SWING_LSB = 0;
  localparam int DEEMPH_LSB = 4;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int CAL_DONE_BIT = 0;
  localparam int CAL_BUSY_BIT = 1;
  localparam int LINK_INIT_BIT = 2;
  localparam int LINK_UP_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] LINK_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] DRIVER_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing counts in sampling clock cycles
  // ----------------------------------------------------------------
  localparam int POWERUP_DELAY_CYCLES = 8400000;
  localparam int CAL_CYCLES = 2000000;
  localparam int LINK_INIT_CYCLES = 64;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Fixed link parameters
  // ----------------------------------------------------------------
  localparam logic [4:0] PARAM_M = 5'h01;
  localparam logic [4:0] PARAM_N = 5'h10;
  localparam logic [4:0] PARAM_NP = 5'h10;
  localparam logic [1:0] PARAM_CS = 2'h0;
  localparam logic [4:0] PARAM_CF = 5'h00;
  localparam logic [31:0] SAMPLE_SIGN = 32'h0000_8000;

  typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4, DIV_8} clk_div_t;

  typedef enum logic [2:0] {TEST_OFF, TEST_D215, TEST_K285, TEST_ILA, TEST_PRBS7, TEST_PRBS23,
    TEST_RAMP} test_seq_t;

  typedef enum logic [1:0] {SYSREF_PERIODIC, SYSREF_PULSED, SYSREF_ONE_SHOT} sysref_mode_t;

  typedef struct packed {
    logic [2:0] swing;
    logic [2:0] deemph;
  } driver_cfg_t;

  typedef struct packed {
    logic [1:0] octets;
    logic [1:0] samples;
    logic high_density;
  } frame_cfg_t;

  typedef struct packed {
    logic [15:0] sample_a;
    logic [15:0] sample_b;
  } sample_pair_t;

endpackage

// ===== design/cal_link_ctrl.sv
// Calibration sequencer, output format, and transmitter link configuration behind an APB slave.
// Assumes pclk is the divided sampling clock and pins are synchronous to it.
//
// Function
// - Auto-calibrate after power-up delay, no command.
// - Calibration run lasts two million cycles.
// - Power-down then normal starts manual calibration.
// - Two's complement default, optional offset binary.
// - Coding converted before framing and encoding.
// - Subclass 1 and 0 only, never 2.
// - Periodic, pulsed and single-shot SYSREF accepted.
// - One or two lanes, per channel.
// - F, S, HD derived from lanes.
// - M, N, N', CS, CF fixed; no idle.
// - D21.5, K28.5, ILA, PRBS, ramp selectable.
// - No transport, RPAT or JSPAT patterns.
// - No lane polarity inversion offered.
// - Swing and de-emphasis codes 0 to 7.
// - Divide factor change reinitializes the link.
// - Scrambling off at reset; ILA unscrambled.
`timescale 1ns/100ps
`default_nettype none

module cal_link_ctrl #(
  parameter int POWERUP_DELAY = cal_link_pkg::POWERUP_DELAY_CYCLES,
  parameter int CAL_LENGTH = cal_link_pkg::CAL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic supply_clock_ok,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref_in,
  input wire logic ila_active,
  input wire cal_link_pkg::sample_pair_t core_samples,
  output cal_link_pkg::sample_pair_t coded_samples,
  output logic cal_done,
  output logic cal_busy,
  output logic link_reinit,
  output logic core_powered_down,
  output logic scramble_active,
  output logic sysref_event,
  output cal_link_pkg::test_seq_t test_seq,
  output logic subclass1,
  output logic [1:0] lanes_per_channel,
  output cal_link_pkg::frame_cfg_t frame_cfg_a,
  output cal_link_pkg::frame_cfg_t frame_cfg_b,
  output cal_link_pkg::driver_cfg_t driver_cfg
);

  typedef enum logic [1:0] {CAL_WAIT_POWER, CAL_DELAY, CAL_RUN, CAL_IDLE} cal_state_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Frame layout follows from the lane count alone.
  function automatic cal_link_pkg::frame_cfg_t frame_of(input logic two_lanes);
    cal_link_pkg::frame_cfg_t f;
    f.octets = two_lanes ? 2'h1 : 2'h2;
    f.samples = 2'h1;
    f.high_density = two_lanes;
    return f;
  endfunction

  // Offset binary is two's complement with the sign bit flipped.
  function automatic logic [15:0] code_of(input logic [15:0] s, input logic offset_bin);
    return offset_bin ? (s ^ cal_link_pkg::SAMPLE_SIGN[15:0]) : s;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] link_cfg_r;
  logic [31:0] driver_r;
  cal_state_t cal_state_r;
  cal_state_t cal_state_nxt;
  logic [cal_link_pkg::CNT_W-1:0] cnt_r;
  logic [cal_link_pkg::CNT_W-1:0] cnt_nxt;
  logic [6:0] init_cnt_r;
  logic sysref_q_r;
  logic sysref_armed_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic access = psel & penable & clk_en;
  wire logic wr = access & pwrite;
  wire logic sel_ctrl = (paddr == cal_link_pkg::CTRL_OFFSET);
  wire logic sel_link = (paddr == cal_link_pkg::LINK_CFG_OFFSET);
  wire logic sel_drv = (paddr == cal_link_pkg::DRIVER_OFFSET);
  wire logic sel_stat = (paddr == cal_link_pkg::LINK_STATUS_OFFSET);
  wire logic sel_par = (paddr == cal_link_pkg::PARAMS_OFFSET);
  wire logic mapped = sel_ctrl | sel_link | sel_drv | sel_stat | sel_par;
  wire logic wr_ctrl = wr & sel_ctrl;

  wire logic [2:0] test_wr = pwdata[cal_link_pkg::TEST_LSB +: 3];
  wire logic test_ok = (test_wr <= 3'(cal_link_pkg::TEST_RAMP));
  wire logic [2:0] test_keep = test_ok ? test_wr : ctrl_r[cal_link_pkg::TEST_LSB +: 3];
  wire logic [1:0] srm_wr = pwdata[cal_link_pkg::SYSREF_MODE_LSB +: 2];
  wire logic [1:0] srm_keep = (srm_wr == 2'h3) ? ctrl_r[cal_link_pkg::SYSREF_MODE_LSB +: 2] : srm_wr;
  wire logic [1:0] div_new = pwdata[cal_link_pkg::DIV_LSB +: 2];
  wire logic div_changed = wr_ctrl & (div_new != ctrl_r[cal_link_pkg::DIV_LSB +: 2]);
  wire logic [31:0] ctrl_wr_val = {16'h0000, 2'h0, srm_keep, 1'b0, test_keep, 2'h0, div_new,
    pwdata[cal_link_pkg::SUBCLASS_BIT], pwdata[cal_link_pkg::SCRAMBLE_BIT],
    pwdata[cal_link_pkg::OFFSET_BIN_BIT], pwdata[cal_link_pkg::PWRDN_BIT]};

  wire logic pwrdn = ctrl_r[cal_link_pkg::PWRDN_BIT];
  wire logic leave_pwrdn = wr_ctrl & pwrdn & ~pwdata[cal_link_pkg::PWRDN_BIT];
  wire logic in_cal = (cal_state_r == CAL_RUN);
  wire logic done_now = (cal_state_r == CAL_IDLE);

  wire logic [31:0] status_val = {28'h0000000, (init_cnt_r == 7'h00), (init_cnt_r != 7'h00), in_cal, done_now};
  wire logic [31:0] params_val = {10'h000, cal_link_pkg::PARAM_CS, cal_link_pkg::PARAM_CF,
    cal_link_pkg::PARAM_NP, cal_link_pkg::PARAM_N, cal_link_pkg::PARAM_M};
  wire logic [31:0] rd_val = sel_ctrl ? ctrl_r : sel_link ? link_cfg_r : sel_drv ? driver_r :
    sel_stat ? status_val : sel_par ? params_val : 32'h0000_0000;

  wire logic sysref_rise = sysref_in & ~sysref_q_r;
  wire logic one_shot = (ctrl_r[cal_link_pkg::SYSREF_MODE_LSB +: 2] == 2'(cal_link_pkg::SYSREF_ONE_SHOT));
  wire logic sysref_take = sysref_rise & subclass1 & (~one_shot | sysref_armed_r);

  // ----------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------
  wire logic setup_phase = psel & ~penable;
  wire logic pslverr_nxt = setup_phase & ~mapped;
  wire logic [31:0] prdata_nxt = setup_phase ? rd_val : prdata;
  wire logic offset_coding = ctrl_r[cal_link_pkg::OFFSET_BIN_BIT];
  wire cal_link_pkg::sample_pair_t coded_nxt = {code_of(core_samples.sample_a, offset_coding),
    code_of(core_samples.sample_b, offset_coding)};
  wire logic cal_done_nxt = (cal_state_nxt == CAL_IDLE);
  wire logic cal_busy_nxt = (cal_state_nxt == CAL_RUN);
  wire logic link_reinit_nxt = div_changed | (init_cnt_r > 7'h01);
  wire logic scramble_nxt = ctrl_r[cal_link_pkg::SCRAMBLE_BIT] & ~ila_active;
  wire cal_link_pkg::test_seq_t test_seq_nxt =
    cal_link_pkg::test_seq_t'(ctrl_r[cal_link_pkg::TEST_LSB +: 3]);
  wire cal_link_pkg::frame_cfg_t frame_a_nxt =
    frame_of(link_cfg_r[cal_link_pkg::LANES_A_BIT]);
  wire cal_link_pkg::frame_cfg_t frame_b_nxt =
    frame_of(link_cfg_r[cal_link_pkg::LANES_B_BIT]);
  wire cal_link_pkg::driver_cfg_t driver_nxt = {driver_r[cal_link_pkg::SWING_LSB +: 3],
    driver_r[cal_link_pkg::DEEMPH_LSB +: 3]};

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    cal_state_nxt = cal_state_r;
    cnt_nxt = cnt_r;
    case (cal_state_r)
      CAL_WAIT_POWER:
      begin
        if (supply_clock_ok)
        begin
          cal_state_nxt = CAL_DELAY;
          cnt_nxt = '0;
        end
      end
      CAL_DELAY:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == cal_link_pkg::CNT_W'(POWERUP_DELAY - 1))
        begin
          cal_state_nxt = CAL_RUN;
          cnt_nxt = '0;
        end
      end
      CAL_RUN:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (pwrdn)
        begin
          cal_state_nxt = CAL_IDLE;
        end
        else if (cnt_r == cal_link_pkg::CNT_W'(CAL_LENGTH - 1))
        begin
          cal_state_nxt = CAL_IDLE;
        end
      end
      default:
      begin
        cal_state_nxt = cal_state_r;
      end
    endcase
    if (leave_pwrdn && cal_state_r != CAL_WAIT_POWER && cal_state_r != CAL_DELAY)
    begin
      cal_state_nxt = CAL_RUN;
      cnt_nxt = '0;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= cal_link_pkg::CTRL_RESET;
      link_cfg_r <= cal_link_pkg::LINK_CFG_RESET;
      driver_r <= cal_link_pkg::DRIVER_RESET;
      cal_state_r <= CAL_WAIT_POWER;
      cnt_r <= '0;
      init_cnt_r <= 7'h00;
      sysref_q_r <= 1'b0;
      sysref_armed_r <= 1'b0;
    end
    else if (clk_en)
    begin
      cal_state_r <= cal_state_nxt;
      cnt_r <= cnt_nxt;
      sysref_q_r <= sysref_in;
      if (wr_ctrl)
      begin
        ctrl_r <= ctrl_wr_val;
      end
      if (wr & sel_link)
      begin
        link_cfg_r <= {30'h00000000, pwdata[1:0]};
      end
      if (wr & sel_drv)
      begin
        driver_r <= {24'h000000, 1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
      end
      if (div_changed)
      begin
        init_cnt_r <= 7'(cal_link_pkg::LINK_INIT_CYCLES);
      end
      else if (init_cnt_r != 7'h00)
      begin
        init_cnt_r <= init_cnt_r - 7'h01;
      end
      if (wr_ctrl)
      begin
        sysref_armed_r <= 1'b1;
      end
      else if (sysref_take)
      begin
        sysref_armed_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      coded_samples <= '0;
      cal_done <= 1'b0;
      cal_busy <= 1'b0;
      link_reinit <= 1'b0;
      core_powered_down <= 1'b0;
      scramble_active <= 1'b0;
      sysref_event <= 1'b0;
      test_seq <= cal_link_pkg::TEST_OFF;
      subclass1 <= 1'b0;
      lanes_per_channel <= 2'h0;
      frame_cfg_a <= '0;
      frame_cfg_b <= '0;
      driver_cfg <= '0;
    end
    else if (clk_en)
    begin
      pready <= setup_phase;
      pslverr <= pslverr_nxt;
      prdata <= prdata_nxt;
      coded_samples <= coded_nxt;
      cal_done <= cal_done_nxt;
      cal_busy <= cal_busy_nxt;
      link_reinit <= link_reinit_nxt;
      core_powered_down <= pwrdn;
      scramble_active <= scramble_nxt;
      sysref_event <= sysref_take;
      test_seq <= test_seq_nxt;
      subclass1 <= ctrl_r[cal_link_pkg::SUBCLASS_BIT];
      lanes_per_channel <= link_cfg_r[1:0];
      frame_cfg_a <= frame_a_nxt;
      frame_cfg_b <= frame_b_nxt;
      driver_cfg <= driver_nxt;
    end
  end

  // Lane outputs carry no inversion control at all.

endmodule

`default_nettype wire

// ===== tb/cal_link_ctrl_assertions.sv
// Concurrent checks on the calibration and link configuration block.
// Assumes binding to every instance of the block, with its timing parameters.
`timescale 1ns/100ps
`default_nettype none
module cal_link_ctrl_assertions #(
  parameter int POWERUP_DELAY = 20,
  parameter int CAL_LENGTH = 30
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_clock_ok,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ila_active,
  input wire cal_link_pkg::sample_pair_t core_samples,
  input wire cal_link_pkg::sample_pair_t coded_samples,
  input wire logic cal_done,
  input wire logic cal_busy,
  input wire logic scramble_active,
  input wire logic sysref_event,
  input wire cal_link_pkg::test_seq_t test_seq,
  input wire logic subclass1,
  input wire logic [1:0] lanes_per_channel,
  input wire cal_link_pkg::frame_cfg_t frame_cfg_a,
  input wire cal_link_pkg::frame_cfg_t frame_cfg_b
);
  // ------------------------------------------------------------
  // Cycle counters for the power-up delay and the run length.
  // ------------------------------------------------------------
  int pu_cnt_r;
  int cal_cnt_r;
  logic started_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pu_cnt_r <= 0;
      cal_cnt_r <= 0;
      started_r <= 1'b0;
    end
    else
    begin
      pu_cnt_r <= (supply_clock_ok && !started_r) ? pu_cnt_r + 1 : pu_cnt_r;
      cal_cnt_r <= cal_busy ? cal_cnt_r + 1 : 0;
      started_r <= started_r | cal_busy;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("pready did not follow a setup cycle");
  a_apb_idle: assert property (!psel |=> !pready)
    else $error("pready high without a request");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without pslverr");
  a_sign_coding: assert property ($past(presetn, 2) |->
    ((coded_samples ^ $past(core_samples)) & 32'h7fff_7fff) == 32'h0 &&
    (coded_samples[31] ^ $past(core_samples[31])) == (coded_samples[15] ^ $past(core_samples[15])))
    else $error("sample coding changed more than sign bits");
  a_done_busy_excl: assert property (cal_busy |-> !cal_done)
    else $error("done flag high during calibration");
  a_powerup_wait: assert property ($rose(cal_busy) && !started_r |->
    pu_cnt_r >= POWERUP_DELAY - 1 && pu_cnt_r <= POWERUP_DELAY + 2)
    else $error("power-up calibration started at wrong time");
  a_cal_length: assert property ($rose(cal_done) |->
    cal_cnt_r >= CAL_LENGTH - 3 && cal_cnt_r <= CAL_LENGTH + 1)
    else $error("calibration run length wrong");
  a_sysref_gate: assert property (sysref_event |-> subclass1 ##1 !sysref_event)
    else $error("sysref event without subclass 1 or too long");
  a_frame_derive: assert property ($past(presetn, 2) && $stable(lanes_per_channel) |->
    frame_cfg_a == (lanes_per_channel[0] ? 5'h0b : 5'h12) && frame_cfg_b == (lanes_per_channel[1] ? 5'h0b : 5'h12))
    else $error("frame parameters not derived from lanes");
  a_ila_clear: assert property (ila_active |=> !scramble_active)
    else $error("scrambling during ILA");
  a_test_legal: assert property (3'(test_seq) != 3'h7)
    else $error("unsupported test sequence code");
endmodule
bind cal_link_ctrl cal_link_ctrl_assertions #(.POWERUP_DELAY(POWERUP_DELAY), .CAL_LENGTH(CAL_LENGTH)) chk_u (
  .pclk(pclk), .presetn(presetn), .supply_clock_ok(supply_clock_ok), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .ila_active(ila_active), .core_samples(core_samples),
  .coded_samples(coded_samples), .cal_done(cal_done), .cal_busy(cal_busy), .scramble_active(scramble_active),
  .sysref_event(sysref_event), .test_seq(test_seq), .subclass1(subclass1),
  .lanes_per_channel(lanes_per_channel), .frame_cfg_a(frame_cfg_a), .frame_cfg_b(frame_cfg_b));
`default_nettype wire

// ===== tb/cal_link_rx_model.sv
// Far-side link logic: supplies SYSREF edges and the ILA indication.
// Assumes its tasks are called from the testbench, one at a time.
`timescale 1ns/100ps
`default_nettype none
module cal_link_rx_model (
  input wire logic pclk,
  output logic sysref_in,
  output logic ila_active
);
  // Lanes are taken as sent; no inversion is handled here.
  initial
  begin
    sysref_in = 1'b0;
    ila_active = 1'b0;
  end
  task automatic sysref_pulse();
    @(posedge pclk);
    sysref_in <= 1'b1;
    repeat (3) @(posedge pclk);
    sysref_in <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic set_ila(input logic v);
    @(posedge pclk);
    ila_active <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/cal_link_ctrl_tb_top.sv
// Directed testbench for the calibration and link configuration block.
// Assumes package, block, checker and far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module cal_link_ctrl_tb_top;
  localparam int PD = 20;
  localparam int CL = 30;
  localparam logic [31:0] DIV3 = 32'h0000_0030;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic supply_clock_ok = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sysref_in;
  logic ila_active;
  cal_link_pkg::sample_pair_t core_samples = '0;
  cal_link_pkg::sample_pair_t coded_samples;
  logic cal_done, cal_busy, link_reinit, core_powered_down, scramble_active, sysref_event, subclass1;
  cal_link_pkg::test_seq_t test_seq;
  logic [1:0] lanes_per_channel;
  cal_link_pkg::frame_cfg_t frame_cfg_a, frame_cfg_b;
  cal_link_pkg::driver_cfg_t driver_cfg;
  int num_errors = 0;
  int n_compared = 0;
  int n_events = 0;
  int cnt;
  logic [31:0] rd;
  logic err;
  cal_link_ctrl #(.POWERUP_DELAY(PD), .CAL_LENGTH(CL)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .supply_clock_ok(supply_clock_ok), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysref_in(sysref_in),
    .ila_active(ila_active), .core_samples(core_samples), .coded_samples(coded_samples), .cal_done(cal_done),
    .cal_busy(cal_busy), .link_reinit(link_reinit), .core_powered_down(core_powered_down),
    .scramble_active(scramble_active), .sysref_event(sysref_event), .test_seq(test_seq), .subclass1(subclass1),
    .lanes_per_channel(lanes_per_channel), .frame_cfg_a(frame_cfg_a), .frame_cfg_b(frame_cfg_b),
    .driver_cfg(driver_cfg));
  cal_link_rx_model rx_u (.pclk(pclk), .sysref_in(sysref_in), .ila_active(ila_active));
  // ------------------------------------------------------------
  // Clock, event counter and bus tasks.
  // ------------------------------------------------------------
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (sysref_event === 1'b1) n_events++;
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("Error apb expected ready seen none");
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_settle(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(negedge pclk);
  endtask
  task automatic wait_done(input int b);
    for (cnt = 0; cal_done !== 1'b1 && cnt < b; cnt++) @(posedge pclk);
    if (cal_done !== 1'b1)
    begin
      num_errors++;
      $display("Error cal_done expected 1 seen 0");
      print_verdict();
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cal_link_pkg::CTRL_OFFSET, 32'h0);
    `CHK("ctrl", cal_link_pkg::CTRL_RESET, rd)
    apb(1'b0, cal_link_pkg::PARAMS_OFFSET, 32'h0);
    `CHK("params", {10'h0, cal_link_pkg::PARAM_CS, cal_link_pkg::PARAM_CF, cal_link_pkg::PARAM_NP,
      cal_link_pkg::PARAM_N, cal_link_pkg::PARAM_M}, rd)
    apb(1'b1, 12'h014, 32'h0000_ffff);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("scramble_reset", 1'b0, scramble_active)
    $display("test reset done");
    supply_clock_ok <= 1'b1;
    wait_done(PD + CL + 20);
    `CHK("powerup_time", 1'b1, cnt >= PD + CL - 3 && cnt <= PD + CL + 3)
    apb(1'b0, cal_link_pkg::LINK_STATUS_OFFSET, 32'h0);
    `CHK("status_done", 4'h9, rd[3:0])
    $display("test powerup done");
    core_samples <= 32'h1234_8001;
    repeat (2) @(negedge pclk);
    `CHK("coded_twos", 32'h1234_8001, coded_samples)
    wr_settle(cal_link_pkg::CTRL_OFFSET, 32'h0000_0002);
    `CHK("coded_offset", 32'h9234_0001, coded_samples)
    $display("test coding done");
    for (int d = 1; d < 4; d++)
    begin
      wr_settle(cal_link_pkg::CTRL_OFFSET, 32'(d) << cal_link_pkg::DIV_LSB);
      `CHK("link_reinit", 1'b1, link_reinit)
    end
    @(posedge pclk) clk_en <= 1'b0;
    repeat (70) @(posedge pclk);
    `CHK("reinit_frozen", 1'b1, link_reinit)
    clk_en <= 1'b1;
    repeat (70) @(posedge pclk);
    `CHK("reinit_over", 1'b0, link_reinit)
    wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3 | 32'h1);
    `CHK("powered_down", 1'b1, core_powered_down)
    wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3);
    `CHK("busy_manual", 2'b10, {cal_busy, cal_done})
    wait_done(CL + 20);
    `CHK("manual_time", 1'b1, cnt >= CL - 5 && cnt <= CL + 2)
    wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3 | 32'h1);
    wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3);
    repeat (CL * 5 / 4 + 2) @(posedge pclk);
    `CHK("timed_wait", 1'b1, cal_done)
    $display("test manual calibration done");
    for (int k = 0; k < 8; k++)
    begin
      wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3 | (32'(k) << cal_link_pkg::TEST_LSB));
      `CHK("test_seq", (k == 7) ? 3'h6 : 3'(k), 3'(test_seq))
    end
    for (int k = 0; k < 4; k++)
    begin
      wr_settle(cal_link_pkg::LINK_CFG_OFFSET, 32'(k));
      `CHK("lanes", 2'(k), lanes_per_channel)
      `CHK("frame_b", k[1] ? 5'h0b : 5'h12, frame_cfg_b)
    end
    for (int k = 0; k < 8; k++)
    begin
      wr_settle(cal_link_pkg::DRIVER_OFFSET, 32'(k) | (32'(7 - k) << cal_link_pkg::DEEMPH_LSB));
      `CHK("driver", {3'(k), 3'(7 - k)}, driver_cfg)
    end
    $display("test configuration done");
    n_events = 0;
    rx_u.sysref_pulse();
    `CHK("sysref_sub0", 0, n_events)
    for (int m = 0; m < 3; m++)
    begin
      wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3 | 32'h8 | (32'(m) << cal_link_pkg::SYSREF_MODE_LSB));
      n_events = 0;
      rx_u.sysref_pulse();
      rx_u.sysref_pulse();
      `CHK("sysref_mode", (m == 2) ? 1 : 2, n_events)
    end
    wr_settle(cal_link_pkg::CTRL_OFFSET, DIV3 | 32'h0000_3004);
    apb(1'b0, cal_link_pkg::CTRL_OFFSET, 32'h0);
    `CHK("sysref_hold", 2'h2, rd[13:12])
    `CHK("scramble_on", 1'b1, scramble_active)
    rx_u.set_ila(1'b1);
    repeat (2) @(negedge pclk);
    `CHK("scramble_ila", 1'b0, scramble_active)
    rx_u.set_ila(1'b0);
    $display("test link done");
    print_verdict();
  end
endmodule
`default_nettype wire
